// *** rtl/msmc_top.sv ***
// Mode, status indicator, safe mode and regional transmit control
// Notes on behaviour
// [RL1] Service low forces serial port to 38400 8N1
// [RL2] Service changes no setting; release restores format
// [RL3] Service low forces configuration commands enabled
// [RL4] Indicator high while searching for a frame
// [RL5] Indicator low during each received frame
// [RL6] Indicator low while in doze
// [RL7] Indicator toggles while transmitting
// [RL8] Indicator toggles each second with tool connected
// [RL9] Indicator toggles 500 ms in escape command mode; here only while CTL_CMD_EN is clear
// [RL10] Fault enters safe mode, 250 ms blink, code
// [RL11] Safe mode reboots after five seconds
// [RL12] Safe mode inhibits transmit and receive
// [RL13] Found transmission moves search to receive
// [RL14] Busy channel refuses transmit and flushes data
// [RL15] Threshold 60..117 magnitude; 118 disables sensing
// [RL16] Five minutes transmit then one minute block
// [RL17] Send identifier with every transmission when required
// [RL18] Identifier stored and read back by host
// [RL19] Half period between changes; fault wins
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module msmc_top #(
  parameter int MS_CYCLES = msmc_pkg::CYC_PER_MS // Cycles per ms tick
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Service input, active low
  input wire logic service_n_i,
  // Radio status from the modem core
  input wire logic sync_found_i,
  input wire logic frame_end_i,
  input wire logic tx_req_i,
  input wire logic tx_done_i,
  input wire logic [6:0] rssi_mag_i,
  input wire logic fault_i,
  input wire logic [7:0] fault_code_i,
  // Serial port format in force
  output logic [3:0] uart_baud_o,
  output logic uart_par_en_o,
  output logic uart_par_odd_o,
  output logic uart_stop2_o,
  output logic uart_bits7_o,
  // Command and radio control
  output logic cmd_enable_o,
  output logic tx_enable_o,
  output logic rx_enable_o,
  output logic tx_flush_o,
  output logic reboot_o,
  output logic cid_send_o,
  output logic [35:0] call_id_o,
  // Indicator pin and interrupt
  output logic stat_o,
  output logic irq_o
);
  msmc_pkg::msmc_state_e state; // Operating state
  msmc_pkg::msmc_state_e next_state;
  logic [msmc_pkg::CTL_W-1:0] ctrl; // Stored configuration
  logic [6:0] cs_thr; // Carrier sense threshold, dBm magnitude
  logic [35:0] call_id; // Identifier, nine BCD digits
  logic [7:0] fault_code; // Latched fault code
  logic [msmc_pkg::EV_W-1:0] irq_stat; // Sticky events
  logic [msmc_pkg::EV_W-1:0] irq_en; // Event enables
  logic [msmc_pkg::EV_W-1:0] ev; // Events this cycle
  logic [31:0] ms_cnt; // Tick prescaler
  logic ms_tick;
  logic [12:0] safe_ms; // Time spent in safe mode
  logic [18:0] txon_ms; // Accumulated transmit time
  logic [15:0] txoff_ms; // Remaining block time
  logic tx_block; // Time limit block active
  logic service; // Service input asserted
  logic cs_busy; // Channel stronger than threshold
  logic tx_refuse;
  logic safe_done;
  logic lim_hit;
  logic bus_req; // Request seen this cycle
  logic wr_en;
  logic [31:0] wmask; // Byte lane mask
  logic [31:0] rd_word;

  assign service = !service_n_i;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = bus_req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Millisecond tick shared by every timer
  always_ff @(posedge clk_i) begin
    if (rst_i || ms_tick) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_cnt + 32'h1;
    end
  end
  assign ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));

  // Bus answers one cycle after the request, then drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data is registered with the ack; unmapped reads zero
  always_comb begin
    rd_word = 32'h0;
    unique case (wb_adr_i)
      msmc_pkg::OFS_CTRL: rd_word = 32'(ctrl);
      msmc_pkg::OFS_CS_THR: rd_word = 32'(cs_thr);
      msmc_pkg::OFS_CID_LO: rd_word = call_id[31:0];
      msmc_pkg::OFS_CID_HI: rd_word = 32'(call_id[35:32]);
      msmc_pkg::OFS_STATUS: rd_word = {16'h0, fault_code, 1'b0, stat_o, tx_block,
                                       cmd_enable_o, service, state};
      msmc_pkg::OFS_IRQ_STAT: rd_word = 32'(irq_stat);
      msmc_pkg::OFS_IRQ_EN: rd_word = 32'(irq_en);
      default: rd_word = 32'h0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= rd_word;
    end
  end

  // Stored configuration; service access never writes it
  // [RL2] settings left alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= msmc_pkg::CTRL_RST;
    end else if (wr_en && wb_adr_i == msmc_pkg::OFS_CTRL) begin
      ctrl <= (ctrl & ~wmask[msmc_pkg::CTL_W-1:0]) | (wb_dat_i[msmc_pkg::CTL_W-1:0] & wmask[msmc_pkg::CTL_W-1:0]);
    end
  end

  // Threshold write clamps into the legal range
  // [RL15] threshold range clamp
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_thr <= msmc_pkg::CS_THR_RST;
    end else if (wr_en && wb_adr_i == msmc_pkg::OFS_CS_THR && wb_sel_i[0]) begin
      if (wb_dat_i[6:0] < msmc_pkg::CS_MAX_MAG) begin
        cs_thr <= msmc_pkg::CS_MAX_MAG;
      end else if (wb_dat_i[6:0] > msmc_pkg::CS_OFF_MAG || wb_dat_i[7]) begin
        cs_thr <= msmc_pkg::CS_OFF_MAG;
      end else begin
        cs_thr <= wb_dat_i[6:0];
      end
    end
  end

  // Identifier set by the host and read back unchanged
  // [RL18] identifier store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      call_id <= 36'h0;
    end else if (wr_en && wb_adr_i == msmc_pkg::OFS_CID_LO) begin
      call_id[31:0] <= (call_id[31:0] & ~wmask) | (wb_dat_i & wmask);
    end else if (wr_en && wb_adr_i == msmc_pkg::OFS_CID_HI && wb_sel_i[0]) begin
      call_id[35:32] <= wb_dat_i[3:0];
    end
  end
  assign call_id_o = call_id;

  // Serial format: service forces 38400 8N1, release restores
  // [RL1] service format override
  always_comb begin
    if (service) begin
      uart_baud_o = msmc_pkg::BAUD_38400;
      uart_par_en_o = 1'b0;
      uart_par_odd_o = 1'b0;
      uart_stop2_o = 1'b0;
      uart_bits7_o = 1'b0;
    end else begin
      // [RL2] configured format resumes
      uart_baud_o = ctrl[msmc_pkg::CTL_BAUD_LSB +: 4];
      uart_par_en_o = ctrl[msmc_pkg::CTL_PAR_EN];
      uart_par_odd_o = ctrl[msmc_pkg::CTL_PAR_ODD];
      uart_stop2_o = ctrl[msmc_pkg::CTL_STOP2];
      uart_bits7_o = ctrl[msmc_pkg::CTL_BITS7];
    end
  end

  // [RL3] commands forced on
  assign cmd_enable_o = service || ctrl[msmc_pkg::CTL_CMD_EN] || ctrl[msmc_pkg::CTL_ESC];

  // Carrier sense only in regions that ask for it
  // [RL15] off setting disables
  assign cs_busy = ctrl[msmc_pkg::CTL_CS_REG] && (cs_thr != msmc_pkg::CS_OFF_MAG)
                   && (rssi_mag_i < cs_thr);
  // [RL14] refuse on busy channel
  assign tx_refuse = tx_req_i && (cs_busy || tx_block);
  assign safe_done = ms_tick && (safe_ms == 13'(msmc_pkg::SAFE_REBOOT_MS - 1));
  assign lim_hit = ms_tick && (txon_ms == 19'(msmc_pkg::TXLIM_ON_MS - 1)) && state == msmc_pkg::ST_TRANSMIT;

  // Mode sequencing; faults override everything
  always_comb begin
    next_state = state;
    unique case (state)
      msmc_pkg::ST_SEARCH: begin
        if (ctrl[msmc_pkg::CTL_DOZE]) begin
          next_state = msmc_pkg::ST_DOZE;
        end else if (ctrl[msmc_pkg::CTL_ESC]) begin
          // Command mode keeps the radio idle
          next_state = msmc_pkg::ST_SEARCH;
        end else if (tx_req_i && !tx_refuse) begin
          next_state = msmc_pkg::ST_TRANSMIT;
        // [RL13] sync found
        end else if (sync_found_i) begin
          next_state = msmc_pkg::ST_RECEIVE;
        end
      end
      msmc_pkg::ST_RECEIVE: begin
        if (frame_end_i) begin
          next_state = msmc_pkg::ST_SEARCH;
        end
      end
      msmc_pkg::ST_TRANSMIT: begin
        // Limit expiry cuts the transmission short
        if (tx_done_i || lim_hit) begin
          next_state = msmc_pkg::ST_SEARCH;
        end
      end
      msmc_pkg::ST_DOZE: begin
        if (!ctrl[msmc_pkg::CTL_DOZE]) begin
          next_state = msmc_pkg::ST_SEARCH;
        end
      end
      msmc_pkg::ST_SAFE: begin
        // [RL11] reboot after dwell
        if (safe_done) begin
          next_state = msmc_pkg::ST_SEARCH;
        end
      end
      default: next_state = msmc_pkg::ST_SEARCH;
    endcase
    // [RL10] fault enters safe mode
    if (fault_i) begin
      next_state = msmc_pkg::ST_SAFE;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= msmc_pkg::ST_SEARCH;
    end else begin
      state <= next_state;
    end
  end

  // Fault code latch, readable in status
  // [RL10] fault code capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_code <= 8'h0;
    end else if (fault_i) begin
      fault_code <= fault_code_i;
    end
  end

  // Safe mode dwell timer
  // [RL11] five second count
  always_ff @(posedge clk_i) begin
    if (rst_i || state != msmc_pkg::ST_SAFE || fault_i) begin
      safe_ms <= 13'h0;
    end else if (ms_tick) begin
      safe_ms <= safe_ms + 13'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reboot_o <= 1'b0;
    end else begin
      reboot_o <= (state == msmc_pkg::ST_SAFE) && safe_done && !fault_i;
    end
  end

  // Transmit time accounting and the block that follows
  // [RL16] limit and block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txon_ms <= 19'h0;
      txoff_ms <= 16'h0;
      tx_block <= 1'b0;
    end else if (lim_hit && ctrl[msmc_pkg::CTL_TXL_REG]) begin
      txon_ms <= 19'h0;
      txoff_ms <= 16'(msmc_pkg::TXLIM_OFF_MS - 1);
      tx_block <= 1'b1;
    end else if (tx_block && ms_tick) begin
      if (txoff_ms == 16'h0) begin
        tx_block <= 1'b0;
      end else begin
        txoff_ms <= txoff_ms - 16'h1;
      end
    end else if (ms_tick && state == msmc_pkg::ST_TRANSMIT && ctrl[msmc_pkg::CTL_TXL_REG]) begin
      txon_ms <= txon_ms + 19'h1;
    end
  end

  // Flush buffered data on a refused transmit
  // [RL14] discard buffered data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_flush_o <= 1'b0;
    end else begin
      tx_flush_o <= state == msmc_pkg::ST_SEARCH && tx_refuse && !fault_i && !ctrl[msmc_pkg::CTL_DOZE];
    end
  end

  // Radio enables; safe mode silences the radio, command mode blocks receive and new transmissions
  // [RL12] inhibit in safe mode
  assign tx_enable_o = (state == msmc_pkg::ST_TRANSMIT);
  assign rx_enable_o = (state == msmc_pkg::ST_SEARCH || state == msmc_pkg::ST_RECEIVE) && !ctrl[msmc_pkg::CTL_ESC];
  // [RL17] identifier with transmission
  assign cid_send_o = tx_enable_o && ctrl[msmc_pkg::CTL_CID_REG];

  // Toggle generators, one per blinking pattern
  msmc_blink_if bl[msmc_pkg::BL_N] ();
  msmc_blink #(.HALF_MS(msmc_pkg::FAULT_HALF_MS)) u_bl_fault (.clk_i(clk_i), .rst_i(rst_i), .b(bl[0]));
  msmc_blink #(.HALF_MS(msmc_pkg::ESC_HALF_MS)) u_bl_esc (.clk_i(clk_i), .rst_i(rst_i), .b(bl[1]));
  msmc_blink #(.HALF_MS(msmc_pkg::TOOL_HALF_MS)) u_bl_tool (.clk_i(clk_i), .rst_i(rst_i), .b(bl[2]));
  msmc_blink #(.HALF_MS(msmc_pkg::TX_HALF_MS)) u_bl_tx (.clk_i(clk_i), .rst_i(rst_i), .b(bl[3]));
  assign bl[0].tick = ms_tick;
  assign bl[1].tick = ms_tick;
  assign bl[2].tick = ms_tick;
  assign bl[3].tick = ms_tick;
  // [RL10] fault blink enable
  assign bl[0].en = (state == msmc_pkg::ST_SAFE);
  // [RL9] escape mode blink
  assign bl[1].en = ctrl[msmc_pkg::CTL_ESC] && !ctrl[msmc_pkg::CTL_CMD_EN];
  // [RL8] tool connected blink
  assign bl[2].en = ctrl[msmc_pkg::CTL_TOOL];
  // [RL7] transmit blink
  assign bl[3].en = (state == msmc_pkg::ST_TRANSMIT);

  // Indicator level, registered so the pin never glitches
  // [RL19] fault pattern first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_o <= 1'b1;
    end else if (state == msmc_pkg::ST_SAFE) begin
      stat_o <= bl[0].lvl;
    end else if (ctrl[msmc_pkg::CTL_TOOL]) begin
      stat_o <= bl[2].lvl;
    end else if (bl[1].en) begin
      stat_o <= bl[1].lvl;
    // [RL6] low in doze
    end else if (state == msmc_pkg::ST_DOZE) begin
      stat_o <= 1'b0;
    end else if (state == msmc_pkg::ST_TRANSMIT) begin
      stat_o <= bl[3].lvl;
    // [RL5] low during frame
    end else if (state == msmc_pkg::ST_RECEIVE) begin
      stat_o <= 1'b0;
    // [RL4] high while searching
    end else begin
      stat_o <= 1'b1;
    end
  end

  // Events for the interrupt status
  always_comb begin
    ev = '0;
    ev[msmc_pkg::EV_FAULT] = fault_i;
    ev[msmc_pkg::EV_TX_REFUSED] = tx_flush_o;
    ev[msmc_pkg::EV_TXLIM] = lim_hit && ctrl[msmc_pkg::CTL_TXL_REG];
    ev[msmc_pkg::EV_REBOOT] = reboot_o;
    ev[msmc_pkg::EV_FRAME] = (state == msmc_pkg::ST_SEARCH) && (next_state == msmc_pkg::ST_RECEIVE);
  end

  // Sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else if (wr_en && wb_adr_i == msmc_pkg::OFS_IRQ_CLR) begin
      irq_stat <= (irq_stat & ~(wb_dat_i[msmc_pkg::EV_W-1:0] & wmask[msmc_pkg::EV_W-1:0])) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en <= '0;
    end else if (wr_en && wb_adr_i == msmc_pkg::OFS_IRQ_EN && wb_sel_i[0]) begin
      irq_en <= wb_dat_i[msmc_pkg::EV_W-1:0];
    end
  end
  assign irq_o = |(irq_stat & irq_en);
endmodule : msmc_top
`default_nettype wire

// *** inc/msmc_pkg.sv ***
// Shared constants and types for the module status and mode control block
package msmc_pkg;
  // Clock rate and the millisecond tick derived from it
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  // Indicator half periods, time between level changes, in ms
  localparam int FAULT_HALF_MS = 250;
  localparam int ESC_HALF_MS = 500;
  localparam int TOOL_HALF_MS = 1000;
  localparam int TX_HALF_MS = 50;
  // Safe mode dwell before the automatic reboot, in ms
  localparam int SAFE_REBOOT_MS = 5000;
  // Transmit time limit and the following block, in minutes and ms
  localparam int MS_PER_MIN = 60000;
  localparam int TXLIM_ON_MIN = 5;
  localparam int TXLIM_OFF_MIN = 1;
  localparam int TXLIM_ON_MS = TXLIM_ON_MIN * MS_PER_MIN;
  localparam int TXLIM_OFF_MS = TXLIM_OFF_MIN * MS_PER_MIN;
  // Carrier sense threshold, magnitude of dBm
  localparam logic [6:0] CS_MAX_MAG = 7'h3c;
  localparam logic [6:0] CS_MIN_MAG = 7'h75;
  localparam logic [6:0] CS_OFF_MAG = 7'h76;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CS_THR = 8'h04;
  localparam logic [7:0] OFS_CID_LO = 8'h08;
  localparam logic [7:0] OFS_CID_HI = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1c;
  // Control register field positions
  localparam int CTL_BAUD_LSB = 0;
  localparam int CTL_PAR_EN = 4;
  localparam int CTL_PAR_ODD = 5;
  localparam int CTL_STOP2 = 6;
  localparam int CTL_BITS7 = 7;
  localparam int CTL_CMD_EN = 8;
  localparam int CTL_ESC = 9;
  localparam int CTL_TOOL = 10;
  localparam int CTL_DOZE = 11;
  localparam int CTL_CS_REG = 12;
  localparam int CTL_TXL_REG = 13;
  localparam int CTL_CID_REG = 14;
  localparam int CTL_W = 15;
  // Baud codes: 38400 is the service format
  localparam logic [3:0] BAUD_38400 = 4'h5;
  localparam logic [3:0] BAUD_DEFAULT = 4'h3;
  // Reset values
  localparam logic [14:0] CTRL_RST = 15'h0103;
  localparam logic [6:0] CS_THR_RST = 7'h76;
  // Event bits
  localparam int EV_FAULT = 0;
  localparam int EV_TX_REFUSED = 1;
  localparam int EV_TXLIM = 2;
  localparam int EV_REBOOT = 3;
  localparam int EV_FRAME = 4;
  localparam int EV_W = 5;
  // Indicator sources
  localparam int BL_FAULT = 0;
  localparam int BL_ESC = 1;
  localparam int BL_TOOL = 2;
  localparam int BL_TX = 3;
  localparam int BL_N = 4;
  // Operating states
  typedef enum logic [2:0] {
    ST_SEARCH = 3'b000,
    ST_RECEIVE = 3'b001,
    ST_TRANSMIT = 3'b010,
    ST_DOZE = 3'b011,
    ST_SAFE = 3'b100
  } msmc_state_e;
endpackage : msmc_pkg

// *** inc/msmc_blink_if.sv ***
// Bundle between the controller and one indicator toggle generator
`timescale 1ns/100ps
`default_nettype none
interface msmc_blink_if;
  logic tick; // Millisecond tick
  logic en; // Run the toggle pattern
  logic lvl; // Toggled level
  modport gen(input tick, input en, output lvl);
  modport user(output tick, output en, input lvl);
endinterface : msmc_blink_if
`default_nettype wire

// *** rtl/msmc_blink.sv ***
// Toggle generator: flips its level every HALF_MS milliseconds while enabled
`timescale 1ns/100ps
`default_nettype none
module msmc_blink #(
  parameter int HALF_MS = 250
) (
  input wire logic clk_i,
  input wire logic rst_i,
  msmc_blink_if.gen b
);
  localparam int CW = $clog2(HALF_MS + 1);
  logic [CW-1:0] cnt; // Elapsed ms in this half period

  // Count ms; restart from a low level whenever disabled
  always_ff @(posedge clk_i) begin
    if (rst_i || !b.en) begin
      cnt <= '0;
      b.lvl <= 1'b0;
    end else if (b.tick) begin
      if (cnt == CW'(HALF_MS - 1)) begin
        cnt <= '0;
        b.lvl <= !b.lvl;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule : msmc_blink
`default_nettype wire

// *** test/msmc_asserts.sv ***
// Port assertions for the status and mode control block
`timescale 1ns/100ps
`default_nettype none
module msmc_asserts #(
  parameter int MS_CYCLES = 4 // Cycles per ms tick
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic service_n_i,
  input wire logic fault_i,
  input wire logic tx_req_i,
  input wire logic [3:0] uart_baud_o,
  input wire logic uart_par_en_o,
  input wire logic uart_par_odd_o,
  input wire logic uart_stop2_o,
  input wire logic uart_bits7_o,
  input wire logic cmd_enable_o,
  input wire logic tx_enable_o,
  input wire logic rx_enable_o,
  input wire logic tx_flush_o,
  input wire logic reboot_o,
  input wire logic cid_send_o,
  input wire logic stat_o
);
  // Windows in cycles; tick phase blurs the edges a little
  localparam int RB_LO = 4999 * MS_CYCLES;
  localparam int RB_HI = 5001 * MS_CYCLES + 4;
  localparam int BL_LO = 250 * MS_CYCLES - 2;
  localparam int BL_HI = 250 * MS_CYCLES + 1;
  int since_flt; // Cycles since the last fault
  int gap; // Cycles since the last indicator change
  int nchg; // Indicator changes in this safe spell
  logic safe_q; // Safe mode as seen from the ports
  logic stat_d; // Indicator one cycle ago
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Helper timers; the first two changes after a fault are skipped as their phase is loose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_flt <= 0;
      gap <= 0;
      nchg <= 0;
      safe_q <= 1'b0;
      stat_d <= 1'b1;
    end else begin
      stat_d <= stat_o;
      since_flt <= fault_i ? 0 : since_flt + 1;
      gap <= (stat_o != stat_d) ? 0 : gap + 1;
      safe_q <= fault_i ? 1'b1 : (reboot_o ? 1'b0 : safe_q);
      nchg <= (fault_i || reboot_o) ? 0 : nchg + ((stat_o != stat_d && nchg < 3) ? 1 : 0);
    end
  end
  svc_format_a: assert property (!service_n_i |-> uart_baud_o == msmc_pkg::BAUD_38400
    && !uart_par_en_o && !uart_par_odd_o && !uart_stop2_o && !uart_bits7_o) else $error("service format wrong");
  svc_cmd_a: assert property (!service_n_i |-> cmd_enable_o)
    else $error("commands not forced on");
  safe_quiet_a: assert property (fault_i |=> (!tx_enable_o && !rx_enable_o)[*8])
    else $error("radio active in safe mode");
  flush_idle_a: assert property (tx_flush_o |-> $past(tx_req_i) && !tx_enable_o)
    else $error("flush without refused request");
  tx_cause_a: assert property ($rose(tx_enable_o) |-> $past(tx_req_i))
    else $error("transmit without request");
  cid_with_tx_a: assert property (cid_send_o |-> tx_enable_o)
    else $error("identifier outside transmission");
  reboot_time_a: assert property (reboot_o |-> since_flt >= RB_LO && since_flt <= RB_HI)
    else $error("reboot at wrong time");
  safe_blink_a: assert property (safe_q && nchg >= 2 && $changed(stat_o) |-> gap >= BL_LO && gap <= BL_HI)
    else $error("safe blink interval wrong");
  cover property (reboot_o);
  cover property ($rose(tx_enable_o));
  cover property (tx_flush_o);
endmodule : msmc_asserts
bind msmc_top msmc_asserts #(.MS_CYCLES(MS_CYCLES)) asserts_i (.clk_i, .rst_i, .service_n_i, .fault_i, .tx_req_i,
  .uart_baud_o, .uart_par_en_o, .uart_par_odd_o, .uart_stop2_o, .uart_bits7_o, .cmd_enable_o, .tx_enable_o,
  .rx_enable_o, .tx_flush_o, .reboot_o, .cid_send_o, .stat_o);
`default_nettype wire

// *** test/msmc_led_model.sv ***
// Indicator LED watcher: times the gaps between level changes
`timescale 1ns/100ps
`default_nettype none
module msmc_led_model (
  input wire logic clk_i,
  input wire logic stat_i, // Indicator pin
  output var int gap_o, // Cycles between the last two changes
  output var int edges_o // Level changes seen
);
  int cnt = 0; // Cycles since the last change
  logic lvl = 1'b1; // Level one cycle ago
  initial begin
    gap_o = 0;
    edges_o = 0;
  end
  // The LED only shows levels, so only changes and their spacing matter
  always @(posedge clk_i) begin
    lvl <= stat_i;
    if (stat_i !== lvl) begin
      gap_o <= cnt + 1;
      edges_o <= edges_o + 1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : msmc_led_model
`default_nettype wire

// *** test/msmc_test.sv ***
// Self-checking bench for the status and mode control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module msmc_test;
  localparam int MS = 4; // Shortened ms tick keeps the run short
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, svc_n = 1'b1, sync = 1'b0, fend = 1'b0;
  logic txr = 1'b0, txd = 1'b0, flt = 1'b0;
  logic [7:0] adr = 8'h00, fcode = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [6:0] rssi = 7'h7f; // Weak channel by default
  wire logic [31:0] rdat;
  wire logic [35:0] cid;
  wire logic [3:0] baud;
  wire logic ack, pe, po, s2, b7, cmd, txe, rxe, fl, rb, cids, stat, irq;
  int gap, edges, num_errors = 0, num_checks = 0, cycles = 0;
  msmc_top #(.MS_CYCLES(MS)) DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .service_n_i(svc_n), .sync_found_i(sync),
    .frame_end_i(fend), .tx_req_i(txr), .tx_done_i(txd), .rssi_mag_i(rssi), .fault_i(flt), .fault_code_i(fcode),
    .uart_baud_o(baud), .uart_par_en_o(pe), .uart_par_odd_o(po), .uart_stop2_o(s2), .uart_bits7_o(b7),
    .cmd_enable_o(cmd), .tx_enable_o(txe), .rx_enable_o(rxe), .tx_flush_o(fl), .reboot_o(rb), .cid_send_o(cids),
    .call_id_o(cid), .stat_o(stat), .irq_o(irq));
  msmc_led_model led (.clk_i, .stat_i(stat), .gap_o(gap), .edges_o(edges));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // One classic cycle; request held until ack is seen at an edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    `CHK(q & m, e)
  endtask : rdc
  // Stops on an edge: inputs then change there, outputs read are last cycle's settled values
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step
  // Let a toggle pattern settle, then read its spacing
  task automatic blink(input int e);
    int e0;
    e0 = edges;
    while (edges - e0 < 3) @(posedge clk_i);
    `CHK(gap, e)
  endtask : blink
  task automatic t_rx;
    `CHK(stat, 1'b1)
    sync <= 1'b1;
    step(1);
    sync <= 1'b0;
    step(2);
    `CHK(stat, 1'b0)
    rdc(8'h10, 32'h7, 32'h1);
    fend <= 1'b1;
    step(1);
    fend <= 1'b0;
    step(2);
    `CHK(stat, 1'b1)
    $display("receive test done");
  endtask : t_rx
  task automatic t_service;
    wr(8'h00, 32'h00f2);
    step(1);
    svc_n <= 1'b0;
    step(2);
    `CHK({baud, pe, po, s2, b7}, {4'h5, 4'h0})
    `CHK(cmd, 1'b1)
    rdc(8'h00, 32'h7fff, 32'h00f2);
    rdc(8'h10, 32'h7, 32'h0);
    svc_n <= 1'b1;
    step(2);
    `CHK({baud, pe, po, s2, b7, cmd}, {4'h2, 5'h1e})
    $display("service test done");
  endtask : t_service
  task automatic t_blink;
    wr(8'h00, 32'h0503);
    blink(1000 * MS);
    wr(8'h00, 32'h0203);
    blink(500 * MS);
    `CHK({cmd, rxe}, 2'b10)
    $display("blink test done");
  endtask : t_blink
  task automatic t_tx;
    wr(8'h00, 32'h4103);
    wr(8'h08, 32'h87654321);
    wr(8'h0c, 32'h9);
    rdc(8'h08, 32'hffffffff, 32'h87654321);
    rdc(8'h0c, 32'hf, 32'h9);
    `CHK(cid, 36'h987654321)
    txr <= 1'b1;
    step(1);
    txr <= 1'b0;
    step(1);
    `CHK({txe, cids}, 2'b11)
    blink(50 * MS);
    txd <= 1'b1;
    step(1);
    txd <= 1'b0;
    step(2);
    `CHK(txe, 1'b0)
    $display("transmit test done");
  endtask : t_tx
  task automatic t_cs;
    wr(8'h00, 32'h1103);
    wr(8'h04, 32'h50);
    rdc(8'h04, 32'h7f, 32'h50);
    rdc(8'h40, 32'hffffffff, 32'h0);
    rssi <= 7'h46;
    wr(8'h1c, 32'h2);
    txr <= 1'b1;
    step(1);
    txr <= 1'b0;
    // Flush pulse is registered off the refusing edge
    step(1);
    `CHK({fl, txe}, 2'b10)
    step(1);
    `CHK(irq, 1'b1)
    rdc(8'h14, 32'h2, 32'h2);
    wr(8'h18, 32'h2);
    step(1);
    `CHK(irq, 1'b0)
    wr(8'h04, 32'h10);
    rdc(8'h04, 32'h7f, 32'h3c);
    wr(8'h04, 32'h7f);
    rdc(8'h04, 32'h7f, 32'h76);
    txr <= 1'b1;
    step(1);
    txr <= 1'b0;
    step(1);
    `CHK(txe, 1'b1)
    txd <= 1'b1;
    step(1);
    txd <= 1'b0;
    $display("carrier sense test done");
  endtask : t_cs
  task automatic t_fault;
    wr(8'h00, 32'h0903);
    step(3);
    `CHK(stat, 1'b0)
    wr(8'h1c, 32'h1);
    {flt, fcode} <= {1'b1, 8'ha5};
    step(1);
    flt <= 1'b0;
    wr(8'h00, 32'h0503);
    rdc(8'h10, 32'hff07, 32'ha504);
    `CHK(irq, 1'b1)
    blink(250 * MS);
    while (rb !== 1'b1) @(posedge clk_i);
    wr(8'h00, 32'h0103);
    step(3);
    rdc(8'h10, 32'h7, 32'h0);
    wr(8'h18, 32'h1);
    $display("fault test done");
  endtask : t_fault
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // Run limit well above the roughly 35k cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 100000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    step(1);
    t_rx();
    t_service();
    t_blink();
    t_tx();
    t_cs();
    t_fault();
    final_report();
  end
endmodule : msmc_test
`default_nettype wire
